// file: afh_pkg.sv
// Shared constants for the converter FIFO link and its host controller
`default_nettype none
package afh_pkg;
   // Timing base
   localparam int CLK_HZ            = 25_000_000;
   localparam int CLK_NS            = 40;
   localparam int CONV_CYCLES       = 56;
   localparam int CONV_MAX_CYCLES   = 57;
   localparam int CONVERSION_START_N_MIN_CYCLES = 2;
   localparam int ACQ_TIME_NS       = 2000;
   localparam int ACQ_CYCLES        = (ACQ_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int MAX_RATE_HZ       = 100_000;
   localparam int SAMPLE_MIN_CYCLES =
      (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
   localparam int TH_SETTLE_CYCLES  = 2;
   // FIFO shape
   localparam int FIFO_DEPTH        = 8;
   localparam int SAMPLE_W          = 12;
   localparam int DB_W              = 16;
   // Bus word of a FIFO read
   localparam int FW_UNDER          = 12;
   localparam int FW_OVER           = 13;
   // Status/control word fields
   localparam int SC_LEN_LSB        = 0;
   localparam int SC_IRQ_EN         = 3;
   localparam int SC_EMPTY          = 4;
   localparam int SC_RANGE          = 5;
   localparam int SC_FLUSH          = 7;
   localparam int SC_COUNT_LSB      = 8;
   localparam logic [2:0] SC_LEN_RESET = 3'h7;
   // Device address line: low selects FIFO, high selects status/control
   localparam logic ADDR_FIFO       = 1'b0;
   localparam logic ADDR_SC         = 1'b1;
   // Host register map, byte addresses
   localparam logic [7:0] HR_CTRL     = 8'h00;
   localparam logic [7:0] HR_SCWORD   = 8'h04;
   localparam logic [7:0] HR_PERIOD   = 8'h08;
   localparam logic [7:0] HR_CMD      = 8'h0C;
   localparam logic [7:0] HR_LAST     = 8'h10;
   localparam logic [7:0] HR_STATUS   = 8'h14;
   localparam logic [7:0] HR_IRQ_STAT = 8'h18;
   localparam logic [7:0] HR_IRQ_MASK = 8'h1C;
   // Host commands
   localparam logic [1:0] CMD_WR_SC   = 2'h1;
   localparam logic [1:0] CMD_RD_FIFO = 2'h2;
   localparam logic [1:0] CMD_RD_SC   = 2'h3;
   // Interrupt glue
   localparam logic [2:0] IRQ_LEVEL   = 3'h1;
   localparam logic [2:0] FC_IACK     = 3'h7;
endpackage
`default_nettype wire

// file: afh_bus_if.sv
// Parallel bus between converter and host glue
`default_nettype none
interface afh_bus_if;
   import afh_pkg::*;
   logic            cs_n;
   logic            bus_read_strobe_n;
   logic            bus_write_strobe_n;
   logic            addr0;
   logic [DB_W-1:0] db_host;
   logic            db_host_oe;
   logic [DB_W-1:0] db_dev;
   logic            db_dev_oe;
   logic [DB_W-1:0] db;
   logic            busy_n;
   logic            fifo_threshold_irq_n;
   logic            conversion_start_n;
   // Resolved data bus level; floats low when nobody drives
   assign db = db_host_oe ? db_host : (db_dev_oe ? db_dev : '0);
   modport device (
      input  cs_n, bus_read_strobe_n, bus_write_strobe_n, addr0, db,
      input  conversion_start_n,
      output db_dev, db_dev_oe, busy_n, fifo_threshold_irq_n
   );
   modport host (
      output cs_n, bus_read_strobe_n, bus_write_strobe_n, addr0,
      output db_host, db_host_oe, conversion_start_n,
      input  db, busy_n, fifo_threshold_irq_n
   );
endinterface
`default_nettype wire

// file: afh_device.sv
// Converter end: conversion timing, sample FIFO and status/control word
`default_nettype none
module afh_device
   import afh_pkg::*;
(
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic [SAMPLE_W-1:0] SAMPLE_DATA,
   input  wire logic                SAMPLE_UNDER,
   input  wire logic                SAMPLE_OVER,
   output logic                     HOLD,
   output logic                     CONVERTING,
   afh_bus_if.device                BUS
);
   typedef enum {D_TRACK, D_CONVERT} afh_dstate_t;
   localparam int FW_W = SAMPLE_W + 2;

   afh_dstate_t     state_reg;
   logic [FW_W-1:0] smp_s1_reg, smp_s2_reg, held_reg;
   logic [FW_W-1:0] mem [FIFO_DEPTH];
   logic [2:0]      wp_reg, rp_reg, len_reg;
   logic [3:0]      cnt_reg, cnt_next;
   logic            irq_en_reg, range_reg, taken_reg, start_prev_reg;
   logic [6:0]      conv_cnt_reg;
   logic [1:0]      settle_reg;
   logic            rise, strobe, take, rd_take, wr_take, pop, push;
   logic            push_ok, flush, range_any;

   assign rise    = BUS.conversion_start_n & ~start_prev_reg;
   assign strobe  = ~BUS.bus_read_strobe_n | ~BUS.bus_write_strobe_n;
   // Accesses wait while the hold switch settles [R5]
   assign take    = ~BUS.cs_n & strobe & BUS.busy_n & ~taken_reg;
   assign rd_take = take & ~BUS.bus_read_strobe_n;
   assign wr_take = take & ~BUS.bus_write_strobe_n & BUS.bus_read_strobe_n;
   assign pop     = rd_take & (BUS.addr0 == ADDR_FIFO) & (cnt_reg != 4'h0);
   assign flush   = wr_take & (BUS.addr0 == ADDR_SC) & BUS.db[SC_FLUSH];
   // A read taken mid-conversion stalls the counter one cycle [R10]
   assign push    = (state_reg == D_CONVERT) & (conv_cnt_reg == 7'h01)
                    & ~rd_take;
   assign push_ok = push & ((cnt_reg != 4'(FIFO_DEPTH)) | pop);

   // Analog-side result is asynchronous to CLK
   always_ff @(posedge CLK) begin
      smp_s1_reg <= {SAMPLE_OVER, SAMPLE_UNDER, SAMPLE_DATA};
      smp_s2_reg <= smp_s1_reg;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         start_prev_reg <= 1'b1;
         state_reg      <= D_TRACK;
         conv_cnt_reg   <= 7'h00;
         settle_reg     <= 2'h0;
         held_reg       <= '0;
      end else begin
         start_prev_reg <= BUS.conversion_start_n;
         if (settle_reg != 2'h0)
            settle_reg <= settle_reg - 2'h1;
         case (state_reg)
            D_TRACK: begin
               // Start edge freezes the input; count starts next edge [R13]
               if (rise) begin
                  held_reg     <= smp_s2_reg;
                  settle_reg   <= 2'(TH_SETTLE_CYCLES);
                  conv_cnt_reg <= 7'(CONV_CYCLES);
                  state_reg    <= D_CONVERT;
               end
            end
            D_CONVERT: begin
               // Synchronous start gives 56, never past 57 unstalled [R8]
               if (!rd_take) begin
                  conv_cnt_reg <= conv_cnt_reg - 7'h01;
                  if (conv_cnt_reg == 7'h01)
                     state_reg <= D_TRACK;
               end
            end
            default: state_reg <= D_TRACK;
         endcase
      end
   end

   // FIFO storage, oldest word read first [R16]
   always_ff @(posedge CLK) begin
      if (push_ok && !flush)
         mem[wp_reg] <= held_reg;  // Keeps per-word range bits [R4]
   end

   always_comb begin
      cnt_next = cnt_reg;
      if (flush)
         cnt_next = 4'h0;
      else if (push_ok && !pop)
         cnt_next = cnt_reg + 4'h1;
      else if (pop && !push_ok)
         cnt_next = cnt_reg - 4'h1;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wp_reg  <= 3'h0;
         rp_reg  <= 3'h0;
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
         if (flush) begin
            wp_reg <= 3'h0;
            rp_reg <= 3'h0;
         end else begin
            if (push_ok)
               wp_reg <= wp_reg + 3'h1;
            if (pop)
               rp_reg <= rp_reg + 3'h1;  // [R16]
         end
      end
   end

   // Any held word out of range, under or over [R3]
   always_comb begin
      range_any = 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         if (4'(i) < cnt_reg)
            range_any = range_any | mem[rp_reg + 3'(i)][FW_UNDER]
                        | mem[rp_reg + 3'(i)][FW_OVER];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         len_reg    <= SC_LEN_RESET;
         irq_en_reg <= 1'b0;
         range_reg  <= 1'b0;
         taken_reg  <= 1'b0;
      end else begin
         range_reg <= range_any;  // [R3]
         taken_reg <= strobe & (taken_reg | take);
         if (wr_take && BUS.addr0 == ADDR_SC) begin
            len_reg    <= BUS.db[SC_LEN_LSB +: 3];
            irq_en_reg <= BUS.db[SC_IRQ_EN];
         end
      end
   end

   // Read data stand for exactly the cycle after the take
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         BUS.db_dev    <= '0;
         BUS.db_dev_oe <= 1'b0;
      end else begin
         BUS.db_dev_oe <= rd_take;
         if (rd_take) begin
            BUS.db_dev <= '0;
            if (BUS.addr0 == ADDR_FIFO) begin
               if (cnt_reg != 4'h0)
                  BUS.db_dev[FW_W-1:0] <= mem[rp_reg];  // [R4] [R16]
            end else begin
               BUS.db_dev[SC_LEN_LSB +: 3]   <= len_reg;
               BUS.db_dev[SC_IRQ_EN]         <= irq_en_reg;
               BUS.db_dev[SC_EMPTY]          <= (cnt_reg == 4'h0);
               BUS.db_dev[SC_RANGE]          <= range_reg;  // [R3]
               BUS.db_dev[SC_COUNT_LSB +: 4] <= cnt_reg;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         BUS.busy_n               <= 1'b1;
         BUS.fifo_threshold_irq_n <= 1'b1;
         HOLD                     <= 1'b0;
         CONVERTING               <= 1'b0;
      end else begin
         // Low across the track-to-hold switch [R5]
         BUS.busy_n <= ~((state_reg == D_TRACK && rise)
                         || settle_reg > 2'h1);
         // Programmed word count reached [R2]
         BUS.fifo_threshold_irq_n <=
            ~(irq_en_reg && cnt_next >= {1'b0, len_reg} + 4'h1);
         HOLD       <= (state_reg == D_TRACK) ? rise : ~push;
         CONVERTING <= (state_reg == D_CONVERT) ? ~push : rise;
      end
   end
endmodule
`default_nettype wire

// file: afh_host.sv
// Host end: bus glue, conversion-start timer and interrupt glue
//
// How it works
// (R1) Write control word before starting conversions
// (R2) Threshold line falls at programmed word count
// (R3) Bit five flags any out-of-range word
// (R4) Each FIFO word carries under/over bits
// (R5) Accesses stall while hold switch settles
// (R6) Derive read/write strobes from strobe and direction
// (R7) Start pulse lasts at least two clocks
// (R8) Conversion ends within 57 clocks
// (R9) Keep 2 us acquisition before next start
// (R10) Reads during conversion stretch it
// (R11) Never start faster than 100 kHz
// (R12) Encode level, autovector the acknowledge
// (R13) Start edge holds input, count begins next
// (R14) Select with busy gives processor wait
// (R15) Converter shares the processor clock
// (R16) Samples come back oldest first
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
module afh_host
   import afh_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   output logic             IRQ,
   output logic      [2:0]  INTERRUPT_PRIORITY_INPUTS,
   output logic             AUTOVECTOR_ACKNOWLEDGE_N,
   input  wire logic [2:0]  FUNCTION_CODE_OUTPUTS,
   input  wire logic [2:0]  ACK_ADDRESS,
   input  wire logic        ACK_STROBE_N,
   afh_bus_if.host          BUS
);
   typedef enum {H_IDLE, H_SETUP, H_ACC, H_HOLD, H_END} afh_hstate_t;
   localparam int GUARD_CYCLES = CONV_MAX_CYCLES + ACQ_CYCLES;

   afh_hstate_t state_reg;
   logic        host_address_strobe_n;
   logic        rw_reg, is_sc_wr_reg, sc_written_reg, ctrl_en_reg;
   logic [15:0] scword_reg, period_reg, last_reg, tcnt_reg, period_eff;
   logic [1:0]  irq_stat_reg, irq_mask_reg, irq_set, pulse_reg;
   logic [8:0]  guard_reg;
   logic [2:0]  fc_s1_reg, fc_s2_reg, aa_s1_reg, aa_s2_reg;
   logic        as_s1_reg, as_s2_reg;
   logic        cmd_wr, take, start_now;
   logic [1:0]  cmd;

   assign cmd    = WDATA[1:0];
   assign cmd_wr = WR && ADDR == HR_CMD && state_reg == H_IDLE
                   && cmd != 2'h0;
   // Converter takes the access on this edge once busy is high [R5]
   assign take   = state_reg == H_ACC && BUS.busy_n;

   // Bus sequencer
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_reg              <= H_IDLE;
         BUS.cs_n               <= 1'b1;
         host_address_strobe_n  <= 1'b1;
         rw_reg                 <= 1'b1;
         is_sc_wr_reg           <= 1'b0;
         BUS.addr0              <= ADDR_FIFO;
         BUS.db_host            <= '0;
         BUS.db_host_oe         <= 1'b0;
         BUS.bus_read_strobe_n  <= 1'b1;
         BUS.bus_write_strobe_n <= 1'b1;
         last_reg               <= 16'h0000;
      end else begin
         case (state_reg)
            H_IDLE: begin
               if (cmd_wr) begin
                  BUS.cs_n              <= 1'b0;
                  host_address_strobe_n <= 1'b0;
                  rw_reg                <= cmd != CMD_WR_SC;
                  is_sc_wr_reg          <= cmd == CMD_WR_SC;
                  BUS.addr0      <= (cmd == CMD_RD_FIFO) ? ADDR_FIFO
                                                         : ADDR_SC;
                  BUS.db_host    <= scword_reg;
                  BUS.db_host_oe <= cmd == CMD_WR_SC;
                  state_reg      <= H_SETUP;
               end
            end
            H_SETUP: begin
               // Separate strobes from address strobe and direction [R6]
               BUS.bus_read_strobe_n  <= host_address_strobe_n | ~rw_reg;
               BUS.bus_write_strobe_n <= host_address_strobe_n | rw_reg;
               state_reg <= H_ACC;
            end
            H_ACC: begin
               // Select with busy low holds the cycle in wait [R14] [R5]
               if (take)
                  state_reg <= H_HOLD;
            end
            H_HOLD: begin
               if (rw_reg)
                  last_reg <= BUS.db;  // FIFO word or control word [R3] [R4]
               BUS.cs_n               <= 1'b1;
               host_address_strobe_n  <= 1'b1;
               BUS.bus_read_strobe_n  <= 1'b1;
               BUS.bus_write_strobe_n <= 1'b1;
               BUS.db_host_oe         <= 1'b0;
               state_reg              <= H_END;
            end
            H_END: state_reg <= H_IDLE;
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   // Software registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_en_reg    <= 1'b0;
         scword_reg     <= 16'h0000;
         period_reg     <= 16'(SAMPLE_MIN_CYCLES);
         irq_mask_reg   <= 2'h0;
         sc_written_reg <= 1'b0;
      end else begin
         if (WR && ADDR == HR_CTRL)
            ctrl_en_reg <= WDATA[0];
         if (WR && ADDR == HR_SCWORD)
            scword_reg <= WDATA[15:0];
         if (WR && ADDR == HR_PERIOD)
            period_reg <= WDATA[15:0];
         if (WR && ADDR == HR_IRQ_MASK)
            irq_mask_reg <= WDATA[1:0];
         // Timer is locked out until the control word went out [R1]
         if (state_reg == H_HOLD && is_sc_wr_reg)
            sc_written_reg <= 1'b1;  // [R1]
      end
   end

   // Sticky events; a set in the clearing cycle wins
   assign irq_set = {state_reg == H_HOLD, ~BUS.fifo_threshold_irq_n};

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         irq_stat_reg <= 2'h0;
         IRQ          <= 1'b0;
      end else begin
         if (WR && ADDR == HR_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~WDATA[1:0]) | irq_set;
         else
            irq_stat_reg <= irq_stat_reg | irq_set;  // [R2]
         IRQ <= |((irq_stat_reg | irq_set) & irq_mask_reg);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RDATA <= 32'h0000_0000;
      end else if (RD) begin
         case (ADDR)
            HR_CTRL:     RDATA <= {31'h0, ctrl_en_reg};
            HR_SCWORD:   RDATA <= {16'h0, scword_reg};
            HR_PERIOD:   RDATA <= {16'h0, period_reg};
            HR_LAST:     RDATA <= {16'h0, last_reg};
            HR_STATUS:   RDATA <= {29'h0, ~BUS.fifo_threshold_irq_n,
                                   sc_written_reg, state_reg != H_IDLE};
            HR_IRQ_STAT: RDATA <= {30'h0, irq_stat_reg};
            HR_IRQ_MASK: RDATA <= {30'h0, irq_mask_reg};
            default:     RDATA <= 32'h0000_0000;
         endcase
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end

   // Conversion-start timer; the clock is shared, so no sync [R15]
   // Period floors at the 100 kHz sample time [R11]
   assign period_eff = (period_reg < 16'(SAMPLE_MIN_CYCLES))
                       ? 16'(SAMPLE_MIN_CYCLES) : period_reg;
   assign start_now  = ctrl_en_reg && sc_written_reg && pulse_reg == 2'h0
                       && guard_reg == 9'h000
                       && tcnt_reg >= period_eff - 16'h0001;  // [R11]

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         tcnt_reg               <= 16'h0000;
         pulse_reg              <= 2'h0;
         guard_reg              <= 9'h000;
         BUS.conversion_start_n <= 1'b1;
      end else begin
         if (start_now)
            tcnt_reg <= 16'h0000;
         else if (tcnt_reg != 16'hFFFF)
            tcnt_reg <= tcnt_reg + 16'h0001;
         if (start_now) begin
            BUS.conversion_start_n <= 1'b0;
            pulse_reg <= 2'(CONVERSION_START_N_MIN_CYCLES);  // [R7]
         end else if (pulse_reg != 2'h0) begin
            pulse_reg <= pulse_reg - 2'h1;
            if (pulse_reg == 2'h1)
               BUS.conversion_start_n <= 1'b1;  // Rising edge holds [R13]
         end
         // Worst-case conversion plus acquisition before next start
         if (pulse_reg == 2'h1)
            guard_reg <= 9'(GUARD_CYCLES);  // [R8] [R9]
         else if (guard_reg != 9'h000 && !take)
            guard_reg <= guard_reg - 9'h001;  // Read stretch [R10]
      end
   end

   // Acknowledge cycle arrives from processor pins
   always_ff @(posedge CLK) begin
      fc_s1_reg <= FUNCTION_CODE_OUTPUTS;
      fc_s2_reg <= fc_s1_reg;
      aa_s1_reg <= ACK_ADDRESS;
      aa_s2_reg <= aa_s1_reg;
      as_s1_reg <= ACK_STROBE_N;
      as_s2_reg <= as_s1_reg;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         INTERRUPT_PRIORITY_INPUTS <= 3'h7;
         AUTOVECTOR_ACKNOWLEDGE_N  <= 1'b1;
      end else begin
         // Active-low level code of the converter interrupt [R12]
         INTERRUPT_PRIORITY_INPUTS <= BUS.fifo_threshold_irq_n ? 3'h7
                                                               : ~IRQ_LEVEL;
         AUTOVECTOR_ACKNOWLEDGE_N  <= ~(!as_s2_reg && fc_s2_reg == FC_IACK
                                        && aa_s2_reg == IRQ_LEVEL);  // [R12]
      end
   end
endmodule
`default_nettype wire

// file: afh_bus_chk.sv
// Protocol checker for the converter bus between both ends
`default_nettype none
module afh_bus_chk
   import afh_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic cs_n,
   input wire logic bus_read_strobe_n,
   input wire logic bus_write_strobe_n,
   input wire logic db_dev_oe,
   input wire logic busy_n,
   input wire logic fifo_threshold_irq_n,
   input wire logic conversion_start_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       start_q_reg;
   logic [9:0] gap_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Cycles since last start fall; zero until one is seen
   always_ff @(posedge CLK) begin
      start_q_reg <= RST_N ? conversion_start_n : 1'b1;
      if (!RST_N)
         gap_reg <= 10'h000;
      else if (start_q_reg && !conversion_start_n)
         gap_reg <= 10'h001;
      else if (gap_reg != 10'h000 && gap_reg != 10'h3FF)
         gap_reg <= gap_reg + 10'h001;
   end
   AST_START_LOW2: assert property ($fell(conversion_start_n) |=>
      !conversion_start_n) else $error("start pulse too short");
   AST_START_GAP: assert property ($fell(conversion_start_n) &&
      gap_reg != 10'h000 |-> gap_reg >= SAMPLE_MIN_CYCLES)
      else $error("starts closer than the rate limit");
   AST_START_BUSY: assert property ($rose(conversion_start_n) |->
      ##[1:3] !busy_n) else $error("no settle after start");
   AST_BUSY_LEN: assert property ($fell(busy_n) |=>
      !busy_n ##1 busy_n) else $error("settle not two cycles");
   AST_RD_TAKE: assert property ($rose(db_dev_oe) |-> $past(busy_n) &&
      !$past(cs_n) && !$past(bus_read_strobe_n))
      else $error("data driven without a taken read");
   AST_RD_NOT_BUSY: assert property (!busy_n |=> !db_dev_oe)
      else $error("read answered during settle");
   AST_OE_ONE: assert property (db_dev_oe |=> !db_dev_oe)
      else $error("data drive longer than one cycle");
   AST_OE_STROBE: assert property (db_dev_oe |->
      !cs_n && !bus_read_strobe_n) else $error("strobe released early");
   AST_STROBES_APART: assert property (bus_read_strobe_n ||
      bus_write_strobe_n) else $error("both strobes low");
   AST_STROBE_CS: assert property (!bus_read_strobe_n ||
      !bus_write_strobe_n |-> !cs_n) else $error("strobe without select");
   C_READ: cover property (db_dev_oe);
   C_START: cover property ($rose(conversion_start_n));
   C_THRESH: cover property ($fell(fifo_threshold_irq_n));
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench joining converter and host ends
`default_nettype none
module testbench
   import afh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                CLK;
   logic                RST_N;
   logic [SAMPLE_W-1:0] SAMPLE_DATA;
   logic                SAMPLE_UNDER;
   logic                SAMPLE_OVER;
   logic                HOLD;
   logic                CONVERTING;
   logic [7:0]          ADDR;
   logic [31:0]         WDATA;
   logic                WR;
   logic                RD;
   logic [31:0]         RDATA;
   logic                IRQ;
   logic [2:0]          PRIO_CODE;
   logic                AVEC_ACK_N;
   logic [2:0]          FUNC_CODE;
   logic [2:0]          ACK_ADDRESS;
   logic                ACK_STROBE_N;
   int                  fail_count = 0;
   int                  num_checks = 0;
   int                  cyc        = 0;
   int                  conv_len   = 0;
   int                  hold_rises = 0;
   logic                hold_q     = 1'b0;
   afh_bus_if i_afh_bus_if ();
   afh_device i_afh_device (.CLK(CLK), .RST_N(RST_N),
      .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_UNDER(SAMPLE_UNDER),
      .SAMPLE_OVER(SAMPLE_OVER), .HOLD(HOLD), .CONVERTING(CONVERTING),
      .BUS(i_afh_bus_if));
   afh_host i_afh_host (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
      .INTERRUPT_PRIORITY_INPUTS(PRIO_CODE),
      .AUTOVECTOR_ACKNOWLEDGE_N(AVEC_ACK_N),
      .FUNCTION_CODE_OUTPUTS(FUNC_CODE), .ACK_ADDRESS(ACK_ADDRESS),
      .ACK_STROBE_N(ACK_STROBE_N), .BUS(i_afh_bus_if));
   afh_bus_chk i_afh_bus_chk (.CLK(CLK), .RST_N(RST_N),
      .cs_n(i_afh_bus_if.cs_n),
      .bus_read_strobe_n(i_afh_bus_if.bus_read_strobe_n),
      .bus_write_strobe_n(i_afh_bus_if.bus_write_strobe_n),
      .db_dev_oe(i_afh_bus_if.db_dev_oe), .busy_n(i_afh_bus_if.busy_n),
      .fifo_threshold_irq_n(i_afh_bus_if.fifo_threshold_irq_n),
      .conversion_start_n(i_afh_bus_if.conversion_start_n));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      chk(RDATA & m, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge CLK);
      @(negedge CLK);
   endtask
   // Access done is sticky, so clear it first and poll for it
   task automatic cmd(input logic [1:0] c);
      wr(HR_IRQ_STAT, 32'h2);
      wr(HR_CMD, {30'h0, c});
      for (int i = 0; i < 40 && RDATA[1] !== 1'b1; i++) begin
         @(posedge CLK);
         ADDR <= HR_IRQ_STAT;
         RD <= 1'b1;
         @(posedge CLK);
         RD <= 1'b0;
         @(negedge CLK);
      end
      chk(RDATA & 32'h2, 32'h2);
   endtask
   task automatic wait_hold(input int n);
      for (int i = 0; i < 600 && hold_rises < n; i++) @(posedge CLK);
      chk(hold_rises, n);
   endtask
   task automatic t_reset();
      rdc(HR_PERIOD, 32'hFFFFFFFF, 32'h000000FA);
      rdc(8'h20, 32'hFFFFFFFF, 32'h0);
      rdc(HR_STATUS, 32'h3, 32'h0);
      chk({IRQ, PRIO_CODE, AVEC_ACK_N}, 32'hF);
   endtask
   task automatic t_unconfigured();
      wr(HR_CTRL, 32'h1);
      settle(300);
      chk(hold_rises, 0);
      wr(HR_CTRL, 32'h0);
   endtask
   // Two words, threshold two, first over range, second under range
   task automatic t_samples();
      wr(HR_SCWORD, 32'h9);
      cmd(CMD_WR_SC);
      wr(HR_IRQ_MASK, 32'h1);
      wr(HR_CTRL, 32'h1);
      wait_hold(1);
      SAMPLE_DATA <= 12'h3C1;
      SAMPLE_OVER <= 1'b0;
      SAMPLE_UNDER <= 1'b1;
      wait_hold(2);
      for (int i = 0; i < 200 && IRQ !== 1'b1; i++) @(posedge CLK);
      wr(HR_CTRL, 32'h0);
      chk({IRQ, PRIO_CODE}, 32'hE);
      rdc(HR_IRQ_STAT, 32'h1, 32'h1);
      cmd(CMD_RD_SC);
      rdc(HR_LAST, 32'hF30, 32'h220);
      cmd(CMD_RD_FIFO);
      rdc(HR_LAST, 32'hFFFFFFFF, 32'h2A5C);
      cmd(CMD_RD_FIFO);
      rdc(HR_LAST, 32'hFFFFFFFF, 32'h13C1);
      cmd(CMD_RD_SC);
      rdc(HR_LAST, 32'hF30, 32'h010);
      chk(PRIO_CODE, 32'h7);
   endtask
   task automatic t_irq();
      wr(HR_IRQ_MASK, 32'h0);
      settle(2);
      chk(IRQ, 32'h0);
      wr(HR_IRQ_STAT, 32'h3);
      wr(HR_IRQ_MASK, 32'h1);
      settle(2);
      chk(IRQ, 32'h0);
      rdc(HR_IRQ_STAT, 32'h3, 32'h0);
   endtask
   task automatic t_autovector();
      @(posedge CLK);
      FUNC_CODE <= FC_IACK;
      ACK_ADDRESS <= IRQ_LEVEL;
      ACK_STROBE_N <= 1'b0;
      settle(4);
      chk(AVEC_ACK_N, 32'h0);
      @(posedge CLK);
      FUNC_CODE <= 3'h5;
      settle(4);
      chk(AVEC_ACK_N, 32'h1);
   endtask
   // A read inside a conversion stretches it; flush empties the FIFO
   task automatic t_stretch();
      wr(HR_CTRL, 32'h1);
      wait_hold(3);
      wr(HR_CTRL, 32'h0);
      cmd(CMD_RD_SC);
      for (int i = 0; i < 80 && CONVERTING !== 1'b0; i++) @(negedge CLK);
      chk(conv_len, CONV_CYCLES + 1);
      wr(HR_SCWORD, 32'h80);
      cmd(CMD_WR_SC);
      cmd(CMD_RD_SC);
      rdc(HR_LAST, 32'hF3F, 32'h010);
   endtask
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      hold_q <= HOLD;
      if (HOLD === 1'b1 && !hold_q)
         hold_rises <= hold_rises + 1;
      conv_len <= (CONVERTING === 1'b1) ? conv_len + 1 : 0;
      if (CONVERTING === 1'b0 && conv_len != 0)
         chk({31'h0, conv_len <= CONV_MAX_CYCLES}, 32'h1);
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // One clock shared by both ends
   initial begin
      CLK = 1'b0;
      forever #(CLK_NS / 2) CLK = ~CLK;
   end
   initial begin
      RST_N = 1'b0;
      {ADDR, WDATA, WR, RD} = '0;
      SAMPLE_DATA = 12'hA5C;
      SAMPLE_UNDER = 1'b0;
      SAMPLE_OVER = 1'b1;
      FUNC_CODE = 3'h0;
      ACK_ADDRESS = 3'h0;
      ACK_STROBE_N = 1'b1;
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      t_reset();
      t_unconfigured();
      t_samples();
      t_irq();
      t_autovector();
      t_stretch();
      wrap_up();
   end
endmodule
`default_nettype wire
